// [verilog/plcs_supervisor.sv]
// Link cycle supervisor: frame timing, joining, liveness
`timescale 1ns/1ps
// How it works
// - each byte on the line lasts 11 bit periods.
// - data frame is 23 bytes plus 4 per relay and register word.
// - link table frame is 13 bytes plus 2 per joined station.
// - station share is its scan then its data frame.
// - joining starts with a 10-byte joining command.
// - after the wait, 7-byte stop command then one master scan.
// - joining skipped entirely when no station is absent.
// - joining wait defaults 400 ms, programmable 10 to 400 ms.
// - silent station's liveness flag clears after timeout, default 6.4 s.
// - liveness timeout programmable 100 to 6400 ms.
// - joined means powered at the join, still live, and numbered 1 up to highest station.
// - unjoined station's data is not exchanged until it joins.
// - one liveness and one run-mode flag per station 1 to 16.
// - transmission error flag set on any link problem.
module plcs_supervisor #(
   parameter int BAUD = 115200,
   parameter int MS_CYC = plcs_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic first_scan_pulse,
   input wire logic cfg_write,
   input wire logic [1:0] config_keyword_instruction,
   input wire logic [12:0] cfg_value_ms,
   input wire logic [4:0] highest_station,
   input wire logic [7:0] frame_words,
   input wire logic [15:0] scan_cycles,
   input wire logic [15:0] station_powered,
   input wire logic [15:0] station_run,
   input wire logic [15:0] rx_heard,
   input wire logic link_fault,
   input wire logic link_error_clear,
   output logic [15:0] station_liveness_flag,
   output logic [15:0] station_run_flag,
   output logic link_error_flag,
   output logic [8:0] join_wait_keyword,
   output logic [12:0] liveness_timeout_keyword,
   output logic tx_active,
   output logic cycle_valid,
   input wire logic cycle_ready,
   output logic [31:0] cycle_cycles
);
   localparam int BYTE_CYC = plcs_pkg::BITS_PER_BYTE * plcs_pkg::CLK_HZ / BAUD;

   plcs_pkg::plcs_state_t state_reg;
   logic [31:0] cnt_reg, cyc_reg, share_len;
   logic [4:0] stn_reg;
   logic [15:0] joined_reg, in_range;
   logic [31:0] live_cnt_reg [plcs_pkg::NUM_STN];
   logic [15:0] pw_q1_reg, pw_q2_reg, pw_q3_reg, pw_reg;
   logic ft_q1_reg, ft_q2_reg, ft_q3_reg, fault_reg, fault_prev_reg;
   logic buf_ready, cyc_done, absent;

   // Pin synchronisers, change taken when stages 2 and 3 agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pw_q1_reg <= 16'h0000;
         pw_q2_reg <= 16'h0000;
         pw_q3_reg <= 16'h0000;
         pw_reg <= 16'h0000;
         ft_q1_reg <= 1'b0;
         ft_q2_reg <= 1'b0;
         ft_q3_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         pw_q1_reg <= station_powered;
         pw_q2_reg <= pw_q1_reg;
         pw_q3_reg <= pw_q2_reg;
         for (int i = 0; i < plcs_pkg::NUM_STN; i++) begin
            if (pw_q2_reg[i] == pw_q3_reg[i]) begin
               pw_reg[i] <= pw_q3_reg[i];
            end
         end
         ft_q1_reg <= link_fault;
         ft_q2_reg <= ft_q1_reg;
         ft_q3_reg <= ft_q2_reg;
         if (ft_q2_reg == ft_q3_reg) begin
            fault_reg <= ft_q3_reg;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < plcs_pkg::NUM_STN; i++) begin
         in_range[i] = (5'(i + 1) <= highest_station);
      end
   end
   assign absent = |(in_range & ~joined_reg);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         join_wait_keyword <= 9'(plcs_pkg::JOIN_WAIT_DEF_MS);
         liveness_timeout_keyword <= 13'(plcs_pkg::LIVE_DEF_MS);
      end else if (cfg_write) begin
         if (config_keyword_instruction == plcs_pkg::KW_JOIN) begin
            if (cfg_value_ms < 13'(plcs_pkg::JOIN_WAIT_MIN_MS)) begin
               join_wait_keyword <= 9'(plcs_pkg::JOIN_WAIT_MIN_MS);
            end else if (cfg_value_ms > 13'(plcs_pkg::JOIN_WAIT_MAX_MS)) begin
               join_wait_keyword <= 9'(plcs_pkg::JOIN_WAIT_MAX_MS);
            end else begin
               join_wait_keyword <= cfg_value_ms[8:0];
            end
         end else if (config_keyword_instruction == plcs_pkg::KW_LIVE) begin
            if (cfg_value_ms < 13'(plcs_pkg::LIVE_MIN_MS)) begin
               liveness_timeout_keyword <= 13'(plcs_pkg::LIVE_MIN_MS);
            end else if (cfg_value_ms > 13'(plcs_pkg::LIVE_MAX_MS)) begin
               liveness_timeout_keyword <= 13'(plcs_pkg::LIVE_MAX_MS);
            end else begin
               liveness_timeout_keyword <= cfg_value_ms;
            end
         end
      end
   end

   assign share_len = 32'(scan_cycles) + 32'(BYTE_CYC) *
      (32'(plcs_pkg::FRAME_OVERHEAD) +
       32'(plcs_pkg::BYTES_PER_WORD) * 32'(frame_words));
   // Cycle sequencer
   assign cyc_done = (cnt_reg == 32'h0000_0001) || (cnt_reg == 32'h0);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= plcs_pkg::PLCS_IDLE;
         cnt_reg <= 32'h0;
         cyc_reg <= 32'h0;
         stn_reg <= 5'h0;
         joined_reg <= 16'h0000;
      end else begin
         cyc_reg <= cyc_reg + 32'h1;
         if (!cyc_done) begin
            cnt_reg <= cnt_reg - 32'h1;
         end
         unique case (state_reg)
            plcs_pkg::PLCS_IDLE: begin
               if (buf_ready) begin
                  state_reg <= plcs_pkg::PLCS_SHARE;
                  stn_reg <= 5'h0;
                  cyc_reg <= 32'h1;
                  // station one shares only when joined
                  cnt_reg <= joined_reg[0] ? share_len : 32'h0;
               end
            end
            plcs_pkg::PLCS_SHARE: begin
               if (cyc_done) begin
                  if (stn_reg + 5'h1 < highest_station) begin
                     stn_reg <= stn_reg + 5'h1;
                     // only joined stations take a share
                     cnt_reg <= joined_reg[stn_reg[3:0] + 4'h1] ?
                        share_len : 32'h0;
                  end else begin
                     state_reg <= plcs_pkg::PLCS_TABLE;
                     cnt_reg <= 32'(BYTE_CYC) * (32'(plcs_pkg::TABLE_BASE) +
                        32'(plcs_pkg::TABLE_PER_STN) *
                        32'($countones(joined_reg & in_range)));
                  end
               end
            end
            plcs_pkg::PLCS_TABLE: begin
               if (cyc_done) begin
                  if (absent) begin
                     state_reg <= plcs_pkg::PLCS_JOINCMD;
                     cnt_reg <= 32'(BYTE_CYC) * 32'(plcs_pkg::JOIN_CMD_BYTES);
                  end else begin
                     state_reg <= plcs_pkg::PLCS_MSCAN;
                     cnt_reg <= 32'(scan_cycles);
                  end
               end
            end
            plcs_pkg::PLCS_JOINCMD: begin
               if (cyc_done) begin
                  state_reg <= plcs_pkg::PLCS_WAIT;
                  cnt_reg <= 32'(join_wait_keyword) * 32'(MS_CYC);
               end
            end
            plcs_pkg::PLCS_WAIT: begin
               if (cyc_done) begin
                  // only powered stations at this point join
                  joined_reg <= joined_reg | (pw_reg & in_range);
                  state_reg <= plcs_pkg::PLCS_STOPCMD;
                  cnt_reg <= 32'(BYTE_CYC) * 32'(plcs_pkg::STOP_CMD_BYTES);
               end
            end
            plcs_pkg::PLCS_STOPCMD: begin
               if (cyc_done) begin
                  state_reg <= plcs_pkg::PLCS_MSCAN;
                  cnt_reg <= 32'(scan_cycles);
               end
            end
            plcs_pkg::PLCS_MSCAN: begin
               if (cyc_done) begin
                  state_reg <= plcs_pkg::PLCS_IDLE;
               end
            end
         endcase
         for (int i = 0; i < plcs_pkg::NUM_STN; i++) begin
            if (!in_range[i] || !station_liveness_flag[i]) begin
               if (state_reg != plcs_pkg::PLCS_WAIT || !cyc_done) begin
                  joined_reg[i] <= 1'b0;
               end
            end
         end
      end
   end

   assign tx_active = (state_reg != plcs_pkg::PLCS_IDLE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         station_liveness_flag <= 16'h0000;
         station_run_flag <= 16'h0000;
         for (int i = 0; i < plcs_pkg::NUM_STN; i++) begin
            live_cnt_reg[i] <= 32'h0;
         end
      end else begin
         for (int i = 0; i < plcs_pkg::NUM_STN; i++) begin
            if (rx_heard[i] && in_range[i]) begin
               live_cnt_reg[i] <= 32'(liveness_timeout_keyword) * 32'(MS_CYC);
               station_liveness_flag[i] <= 1'b1;
               station_run_flag[i] <= station_run[i];
            end else if (live_cnt_reg[i] > 32'h1) begin
               live_cnt_reg[i] <= live_cnt_reg[i] - 32'h1;
            end else begin
               live_cnt_reg[i] <= 32'h0;
               station_liveness_flag[i] <= 1'b0;
               station_run_flag[i] <= 1'b0;
            end
         end
      end
   end

   // sticky error, set wins over clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_error_flag <= 1'b0;
         fault_prev_reg <= 1'b0;
      end else begin
         fault_prev_reg <= fault_reg;
         if (fault_reg && !fault_prev_reg) begin
            link_error_flag <= 1'b1;
         end else if (link_error_clear) begin
            link_error_flag <= 1'b0;
         end
      end
   end

   // Measured cycle time out through the buffer
   plcs_buf2 #(
      .W(32)
   ) u_buf (
      .clk(clk),
      .resetn(resetn),
      .in_valid(state_reg == plcs_pkg::PLCS_MSCAN && cyc_done),
      .in_ready(buf_ready),
      .in_data(cyc_reg),
      .out_valid(cycle_valid),
      .out_ready(cycle_ready),
      .out_data(cycle_cycles)
   );

   property p_wait_len;
      @(posedge clk) disable iff (!resetn)
      (state_reg == plcs_pkg::PLCS_JOINCMD && cyc_done) |=>
      (cnt_reg == 32'($past(join_wait_keyword)) * 32'(MS_CYC));
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("bad wait");
   property p_skip;
      @(posedge clk) disable iff (!resetn)
      (state_reg == plcs_pkg::PLCS_TABLE && cyc_done && !absent) |=>
      (state_reg == plcs_pkg::PLCS_MSCAN);
   endproperty
   a_skip: assert property (p_skip) else $error("join not skipped");
   // error flag rises after fault edge
   property p_err;
      @(posedge clk) disable iff (!resetn)
      (fault_reg && !fault_prev_reg) |=> link_error_flag;
   endproperty
   a_err: assert property (p_err) else $error("error missed");
   property p_live_rng;
      @(posedge clk) disable iff (!resetn)
      liveness_timeout_keyword >= 13'(plcs_pkg::LIVE_MIN_MS) &&
      liveness_timeout_keyword <= 13'(plcs_pkg::LIVE_MAX_MS);
   endproperty
   a_live_rng: assert property (p_live_rng) else $error("timeout range");
endmodule

// [verilog/plcs_pkg.sv]
// Package: constants for the link cycle supervisor
package plcs_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int BITS_PER_BYTE = 11;
   localparam int FRAME_OVERHEAD = 23;
   localparam int BYTES_PER_WORD = 4;
   localparam int TABLE_BASE = 13;
   localparam int TABLE_PER_STN = 2;
   localparam int JOIN_CMD_BYTES = 10;
   localparam int STOP_CMD_BYTES = 7;
   localparam int JOIN_WAIT_DEF_MS = 400;
   localparam int JOIN_WAIT_MIN_MS = 10;
   localparam int JOIN_WAIT_MAX_MS = 400;
   localparam int LIVE_DEF_MS = 6400;
   localparam int LIVE_MIN_MS = 100;
   localparam int LIVE_MAX_MS = 6400;
   localparam int MS_NS = 1_000_000;
   localparam int CLK_NS = 10;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam int NUM_STN = 16;
   localparam logic [1:0] KW_JOIN = 2'h1;
   localparam logic [1:0] KW_LIVE = 2'h2;
   typedef enum logic [2:0] {
      PLCS_IDLE, PLCS_SHARE, PLCS_TABLE, PLCS_JOINCMD, PLCS_WAIT,
      PLCS_STOPCMD, PLCS_MSCAN
   } plcs_state_t;
endpackage

// [verilog/plcs_buf2.sv]
// Two-entry buffer between link cycle and receiver
`timescale 1ns/1ps
module plcs_buf2 #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_reg [2];
   logic rd_reg, wr_reg;
   logic [1:0] cnt_reg;
   logic push, pop;

   // Handshakes
   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_reg[rd_reg];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_reg <= ~wr_reg;
         end
         if (pop) begin
            rd_reg <= ~rd_reg;
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // Never more than two entries
   property p_cnt_max;
      @(posedge clk) disable iff (!resetn)
      cnt_reg <= 2'h2;
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("overfull");
   // Stalled word holds steady
   property p_hold;
      @(posedge clk) disable iff (!resetn)
      (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
   endproperty
   a_hold: assert property (p_hold) else $error("word lost");
endmodule

// [dv/plcs_peers.sv]
// Peer station model driving the link-side inputs
`timescale 1ns/1ps
module plcs_peers (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] powered_mask,
   input wire logic hush,
   input wire logic fault_cmd,
   output logic [15:0] station_powered,
   output logic [15:0] station_run,
   output logic [15:0] rx_heard,
   output logic link_fault
);
   logic [5:0] tick_reg;
   // Power, run mode and line fault levels
   assign station_powered = powered_mask;
   assign station_run = 16'h0005;
   assign link_fault = fault_cmd;
   // Frames heard from every powered peer every 50 clocks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_reg <= 6'h00;
         rx_heard <= 16'h0000;
      end else begin
         tick_reg <= (tick_reg == 6'h31) ? 6'h00 : tick_reg + 6'h01;
         rx_heard <= (tick_reg == 6'h00 && !hush) ? powered_mask : 16'h0000;
      end
   end
endmodule

// [dv/plcs_supervisor_tb.sv]
// Self-checking bench for the link cycle supervisor
`timescale 1ns/1ps
module plcs_supervisor_tb;
   localparam int BC = 10; // Clocks per byte at the bench baud rate
   localparam int MSC = 10;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cfg_write = 1'b0;
   logic fsp = 1'b0;
   logic hush = 1'b0;
   logic fault_cmd = 1'b0;
   logic err_clr = 1'b0;
   logic cycle_ready = 1'b0;
   logic [1:0] kw = 2'h0;
   logic [12:0] val = 13'h0000;
   logic [4:0] highest = 5'h04;
   logic [7:0] words = 8'h00;
   logic [15:0] scan = 16'h0001;
   logic [15:0] mask = 16'h001f;
   logic [15:0] powered, run, heard, live, run_flag;
   logic err_flag, tx_active, cycle_valid;
   logic [8:0] jw;
   logic [12:0] lw;
   logic [31:0] cyc, got;
   logic fault_w;
   int errors = 0;
   int tests_run = 0;
   int seed = 32'h2ed4;
   int w, sc, i;
   int tk[6] = '{1, 1, 2, 2, 0, 3};
   int tv[6] = '{5, 500, 50, 7000, 123, 200};
   int ej[6] = '{10, 400, 400, 400, 400, 400};
   int el[6] = '{6400, 6400, 100, 6400, 6400, 6400};

   // Clock
   always #5 clk = ~clk;

   plcs_peers peers (.clk(clk), .resetn(resetn), .powered_mask(mask),
      .hush(hush), .fault_cmd(fault_cmd), .station_powered(powered),
      .station_run(run), .rx_heard(heard), .link_fault(fault_w));

   plcs_supervisor #(.BAUD(110_000_000), .MS_CYC(MSC)) DUT (
      .clk(clk), .resetn(resetn), .first_scan_pulse(fsp),
      .cfg_write(cfg_write), .config_keyword_instruction(kw),
      .cfg_value_ms(val), .highest_station(highest),
      .frame_words(words), .scan_cycles(scan), .station_powered(powered),
      .station_run(run), .rx_heard(heard), .link_fault(fault_w),
      .link_error_clear(err_clr), .station_liveness_flag(live),
      .station_run_flag(run_flag), .link_error_flag(err_flag),
      .join_wait_keyword(jw), .liveness_timeout_keyword(lw),
      .tx_active(tx_active), .cycle_valid(cycle_valid),
      .cycle_ready(cycle_ready), .cycle_cycles(cyc));

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task chk(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask

   task cfg(input int k, input int v);
      kw = 2'(k);
      val = 13'(v);
      cfg_write = 1'b1;
      tick(1);
      cfg_write = 1'b0;
   endtask

   // Take one cycle length once the buffer offers it
   task pop(output logic [31:0] v);
      for (i = 0; i < 30000 && cycle_valid !== 1'b1; i++) tick(1);
      if (cycle_valid !== 1'b1) errors++;
      v = cyc;
      tick(1);
   endtask

   // Compare a cycle length with the integer cycle model
   task len_chk(input int n, input int ab);
      int e;
      e = n * (sc + BC * (23 + 4 * w)) + BC * (13 + 2 * n) + sc;
      if (ab != 0) e += BC * 10 + 10 * MSC + BC * 7 + sc;
      pop(got);
      tests_run++;
      if (int'(got) > e + 40 || int'(got) + 40 < e) begin
         errors++;
         $display("[ERR] %0t exp %h got %h", $time, e, got);
      end
   endtask

   task new_frame;
      w = $random(seed) & 3;
      sc = 1 + ($random(seed) & 15);
      words = 8'(w);
      scan = 16'(sc);
   endtask

   task report_and_stop;
      if (errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      #600_000;
      errors++;
      report_and_stop;
   end

   // Main sequence
   initial begin
      tick(2);
      resetn = 1'b1;
      chk(400, jw);
      chk(6400, lw);
      chk(0, err_flag);
      for (int j = 0; j < 6; j++) begin
         cfg(tk[j], tv[j]);
         chk(ej[j], jw);
         chk(el[j], lw);
         tick(1);
      end
      // settings written while the first scan pulse is high
      fsp = 1'b1;
      cfg(1, 10);
      tick(1);
      cfg(2, 500);
      fsp = 1'b0;
      // Receiver stalls until both entries are full
      new_frame();
      tick(8000);
      chk(0, tx_active);
      chk(1, cycle_valid);
      cycle_ready = 1'b1;
      pop(got);
      pop(got);
      len_chk(4, 0);
      len_chk(4, 0);
      chk(16'h000f, live);
      chk(16'h0005, run_flag & 16'h000f);
      // Station 3 powers down, joining runs every cycle
      cycle_ready = 1'b0;
      mask = 16'h001b;
      new_frame();
      tick(8000);
      chk(0, tx_active);
      cycle_ready = 1'b1;
      pop(got);
      pop(got);
      len_chk(3, 1);
      len_chk(3, 1);
      chk(16'h000b, live);
      // Sticky error set only by a rising fault
      fault_cmd = 1'b1;
      tick(1);
      chk(0, err_flag);
      tick(7);
      chk(1, err_flag);
      err_clr = 1'b1;
      tick(1);
      err_clr = 1'b0;
      tick(1);
      chk(0, err_flag);
      fault_cmd = 1'b0;
      tick(8);
      chk(0, err_flag);
      // Silence all peers just after a heard frame
      for (i = 0; i < 100 && heard[0] !== 1'b1; i++) tick(1);
      hush = 1'b1;
      tick(4980);
      chk(1, live[0]);
      tick(40);
      chk(0, live[0]);
      report_and_stop;
   end
endmodule
